//--- pkg/hssc_pkg.sv
// shared constants and types for the side-stream scrambler block
package hssc_pkg;

    // ==========================================
    // sequence generator
    localparam int           HSSC_LFSR_LEN   = 31;
    localparam int           HSSC_TAP_FAR    = 31;
    localparam int           HSSC_TAP_NEAR   = 28;
    localparam logic [30:0]  HSSC_SEED_RST   = 31'h00000000;

    // ==========================================
    // hyperframe geometry
    localparam int           HSSC_BF_PER_HF  = 256;
    localparam int           HSSC_WORDS_BF   = 16;
    localparam int           HSSC_T_DEFAULT  = 32;
    localparam int           HSSC_MASK_CNT   = 16;
    localparam int           HSSC_VER_PLAIN  = 1;
    localparam int           HSSC_VER_SCRAM  = 2;
    localparam logic [7:0]   HSSC_CHECK_BYTE = 8'h50;
    localparam int           HSSC_ACQ_BITS   = 31;
    localparam int           HSSC_FIFO_DEPTH = 8;

    // ==========================================
    // line rate classes
    typedef enum logic [2:0]
    {
        HSSC_RATE_614,
        HSSC_RATE_1228,
        HSSC_RATE_2457,
        HSSC_RATE_3072,
        HSSC_RATE_4915,
        HSSC_RATE_6144,
        HSSC_RATE_9830
    } hssc_rate_t;

    // one byte of the stream with its hyperframe start marker
    typedef struct packed
    {
        logic       hf_start;
        logic [7:0] data;
    } hssc_byte_t;

endpackage

//--- design/hssc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module hssc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= wrap_inc(wr_reg);
            if (pop)
                rd_reg <= wrap_inc(rd_reg);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- design/hssc_top.sv
// side-stream scrambler (tx) and descrambler (rx) for the hyperframe byte stream
`timescale 1ns/1ps

module hssc_top
    import hssc_pkg::*;
#(
    parameter int T = HSSC_T_DEFAULT
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire hssc_rate_t  line_rate,
    input  wire logic [7:0]  proto_version,
    input  wire logic [30:0] tx_seed,
    input  wire hssc_byte_t  tx_in,
    input  wire logic        tx_in_valid,
    output logic             tx_in_ready,
    output hssc_byte_t       tx_out,
    output logic             tx_out_valid,
    input  wire logic        tx_out_ready,
    input  wire hssc_byte_t  rx_in,
    input  wire logic        rx_in_valid,
    output hssc_byte_t       rx_out,
    output logic             rx_out_valid,
    output logic             rx_locked,
    output logic             rx_lock_lost,
    output logic             scram_active
);
    // ==========================================
    // geometry
    localparam int BPW     = T / 8;
    localparam int NB      = 512 * T;
    localparam int IW      = $clog2(NB);

    typedef enum logic [1:0]
    {
        RX_HUNT,
        RX_GATHER,
        RX_LOCK
    } hssc_rx_state_t;

    // ==========================================
    // shared functions
    // eight steps of the generator; returns byte (lsb first) and new state
    function automatic logic [38:0] lfsr_byte(input logic [30:0] s);
        logic [30:0] st;
        logic [7:0]  b;
        st = s;
        b  = '0;
        for (int k = 0; k < 8; k++)
        begin
            b[k] = st[0];
            st   = {st[0] ^ st[3], st[30:1]};
        end
        lfsr_byte = {st, b};
    endfunction

    // zero the mask at control bytes 0/1 of subchannels 0 and 2
    function automatic logic masked_idx(input logic [IW-1:0] n);
        logic hit;
        hit = 1'b0;
        for (int q = 0; q < 4; q++)
        begin
            if (n == IW'(128*T*q) || n == IW'(128*T*q + 1) ||
                n == IW'(128*T*q + 4*T) || n == IW'(128*T*q + 4*T + 1))
                hit = 1'b1;
        end
        masked_idx = hit;
    endfunction

    function automatic logic [IW-1:0] idx_inc(input logic [IW-1:0] n);
        idx_inc = (n == IW'(NB-1)) ? '0 : n + IW'(1);
    endfunction

    // ==========================================
    // enable decode
    wire high_rate = (line_rate == HSSC_RATE_4915) || (line_rate == HSSC_RATE_6144) ||
                     (line_rate == HSSC_RATE_9830);
    wire enable_w  = high_rate && (proto_version == 8'(HSSC_VER_SCRAM));

    // ==========================================
    // transmit path through fifo
    localparam int BW = $bits(hssc_byte_t);
    hssc_byte_t  fifo_out;
    logic        fifo_valid;
    wire         tx_pop = fifo_valid && (!tx_out_valid || tx_out_ready);

    hssc_fifo #(
        .WIDTH (BW),
        .DEPTH (HSSC_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (tx_in),
        .in_valid  (tx_in_valid),
        .in_ready  (tx_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (!tx_out_valid || tx_out_ready)
    );

    logic [30:0]   tx_state_reg;
    logic [IW-1:0] tx_idx_reg;
    logic          en_reg;
    wire  [30:0]   tx_base  = fifo_out.hf_start ? tx_seed : tx_state_reg;
    wire  [IW-1:0] tx_n     = fifo_out.hf_start ? '0 : tx_idx_reg;
    wire  [38:0]   tx_step  = lfsr_byte(tx_base);
    wire  [7:0]    tx_mask  = (masked_idx(tx_n) || !en_reg) ? 8'h00 : tx_step[7:0];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_state_reg <= HSSC_SEED_RST;
            tx_idx_reg   <= '0;
            tx_out       <= '0;
            tx_out_valid <= 1'b0;
            en_reg       <= 1'b0;
            scram_active <= 1'b0;
        end
        else
        begin
            en_reg       <= enable_w;
            scram_active <= en_reg;
            if (tx_pop)
            begin
                tx_state_reg <= tx_step[38:8];
                tx_idx_reg   <= idx_inc(tx_n);
                tx_out.hf_start <= fifo_out.hf_start;
                tx_out.data     <= fifo_out.data ^ tx_mask;
            end
            if (tx_pop)
                tx_out_valid <= 1'b1;
            else if (tx_out_ready)
                tx_out_valid <= 1'b0;
        end
    end

    // ==========================================
    // receive path
    // rx generator keeps stepping so each byte gets its own index's mask
    hssc_rx_state_t rx_st_reg;
    logic [30:0]    rx_state_reg;
    logic [30:0]    acq_reg;
    logic [5:0]     acq_cnt_reg;
    logic [IW-1:0]  rx_idx_reg;
    logic [IW-1:0]  rx_next_idx;
    logic [30:0]    seed_est;
    logic           recovered;
    wire  [IW-1:0]  rx_n     = rx_in.hf_start ? '0 : rx_idx_reg;
    wire  [38:0]    rx_step  = lfsr_byte(rx_state_reg);
    wire            ctl_byte = (rx_n >= IW'(2)) && (rx_n < IW'(BPW));
    wire  [7:0]     rx_mask  = (masked_idx(rx_n) || !en_reg || rx_st_reg != RX_LOCK) ?
                               8'h00 : rx_step[7:0];
    wire  [7:0]     raw_seq  = rx_in.data ^ HSSC_CHECK_BYTE;
    wire  [7:0]     rx_plain = rx_in.data ^ rx_mask;
    wire            chk_bad  = (rx_st_reg == RX_LOCK) && ctl_byte &&
                               (rx_plain != HSSC_CHECK_BYTE);
    // state one byte past the rebuilt seed, loaded at the boundary
    wire  [38:0]    rx_reload = lfsr_byte(seed_est);

    assign rx_next_idx = idx_inc(rx_n);

    // run generator backwards from gathered bits: seq bits 16.. of the frame
    // reconstruct seed so the same state is recreated at the next boundary
    always_comb
    begin
        logic [30:0] st;
        st        = acq_reg;
        // step back 16 bits: previous bit = new_top ^ st[2]
        for (int k = 0; k < 16; k++)
        begin
            st = {st[29:0], st[30] ^ st[2]};
        end
        seed_est  = st;
        recovered = (acq_cnt_reg >= 6'(HSSC_ACQ_BITS));
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_st_reg    <= RX_HUNT;
            rx_state_reg <= HSSC_SEED_RST;
            acq_reg      <= '0;
            acq_cnt_reg  <= '0;
            rx_idx_reg   <= '0;
            rx_out       <= '0;
            rx_out_valid <= 1'b0;
            rx_locked    <= 1'b0;
            rx_lock_lost <= 1'b0;
        end
        else
        begin
            rx_out_valid <= rx_in_valid;
            rx_lock_lost <= 1'b0;
            if (rx_in_valid)
            begin
                rx_idx_reg      <= rx_next_idx;
                rx_out.hf_start <= rx_in.hf_start;
                rx_out.data     <= rx_plain;
                if (!rx_in.hf_start)
                    rx_state_reg <= rx_step[38:8];
                case (rx_st_reg)
                    RX_HUNT:
                    begin
                        if (rx_in.hf_start)
                        begin
                            acq_cnt_reg <= '0;
                            rx_st_reg   <= en_reg ? RX_GATHER : RX_HUNT;
                        end
                    end
                    RX_GATHER:
                    begin
                        if (ctl_byte && !recovered)
                        begin
                            acq_reg     <= {raw_seq, acq_reg[30:8]};
                            acq_cnt_reg <= acq_cnt_reg + 6'd8;
                        end
                        if (rx_in.hf_start)
                        begin
                            if (recovered)
                            begin
                                rx_state_reg <= rx_reload[38:8];
                                rx_st_reg    <= RX_LOCK;
                                rx_locked    <= 1'b1;
                            end
                            else
                                acq_cnt_reg <= '0;
                        end
                    end
                    RX_LOCK:
                    begin
                        if (rx_in.hf_start)
                            rx_state_reg <= rx_reload[38:8];
                        if (chk_bad || !en_reg)
                        begin
                            rx_lock_lost <= chk_bad;
                            rx_locked    <= 1'b0;
                            rx_st_reg    <= RX_HUNT;
                        end
                    end
                    default:
                        rx_st_reg <= RX_HUNT;
                endcase
            end
        end
    end
endmodule

//--- testbench/hssc_top_asserts.sv
// concurrent checks on the scrambler top ports
`timescale 1ns/1ps
module hssc_top_asserts
    import hssc_pkg::*;
#(
    parameter int T = HSSC_T_DEFAULT
)
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire hssc_rate_t  line_rate,
    input wire logic [7:0]  proto_version,
    input wire hssc_byte_t  tx_out,
    input wire logic        tx_out_valid,
    input wire logic        tx_out_ready,
    input wire logic        tx_in_ready,
    input wire hssc_byte_t  rx_in,
    input wire logic        rx_in_valid,
    input wire hssc_byte_t  rx_out,
    input wire logic        rx_out_valid,
    input wire logic        rx_locked,
    input wire logic        rx_lock_lost,
    input wire logic        scram_active
);
    // ==========================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_rx_latency: assert property (rx_in_valid |=> rx_out_valid)
        else $error("rx output valid missing");
    chk_rx_quiet: assert property (!rx_in_valid |=> !rx_out_valid)
        else $error("rx output valid without input");
    chk_rx_plain: assert property (rx_in_valid && !rx_locked |=> rx_out == $past(rx_in))
        else $error("rx data altered while unlocked");
    chk_low_rate: assert property ((line_rate < HSSC_RATE_4915) [*3] |-> !scram_active)
        else $error("scrambler on at low rate");
    chk_ver_plain: assert property ((proto_version != 8'h02) [*3] |-> !scram_active)
        else $error("scrambler on without version 2");
    chk_scram_on: assert property ((line_rate >= HSSC_RATE_4915 && proto_version == 8'h02) [*3]
        |-> scram_active)
        else $error("scrambler off when enabled");
    chk_tx_hold: assert property (tx_out_valid && !tx_out_ready
        |=> tx_out_valid && $stable(tx_out))
        else $error("tx output changed while stalled");
    chk_lost_pulse: assert property (rx_lock_lost |=> !rx_lock_lost ##0 !rx_locked)
        else $error("lock loss not a pulse or lock kept");
    cov_scram: cover property (scram_active && tx_out_valid && tx_out_ready);
    cov_full: cover property (!tx_in_ready);
    cov_hf: cover property (tx_out_valid && tx_out.hf_start);
endmodule

bind hssc_top hssc_top_asserts #(.T(T)) u_chk (.clk(clk), .resetn(resetn),
    .line_rate(line_rate), .proto_version(proto_version), .tx_out(tx_out),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_in_ready(tx_in_ready),
    .rx_in(rx_in), .rx_in_valid(rx_in_valid), .rx_out(rx_out), .rx_out_valid(rx_out_valid),
    .rx_locked(rx_locked), .rx_lock_lost(rx_lock_lost), .scram_active(scram_active));

//--- testbench/hssc_sink.sv
// encoder-side sink model with random backpressure
`timescale 1ns/1ps
module hssc_sink
    import hssc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire hssc_byte_t tx_out,
    input  wire logic       tx_out_valid,
    output logic            tx_out_ready
);
    hssc_byte_t got[$];
    // ready chosen off edge; a transfer is decided before the next rising edge
    always @(negedge clk)
    begin
        tx_out_ready = !stall && ($urandom % 4 != 0);
        if (tx_out_valid && tx_out_ready)
            got.push_back(tx_out);
    end
endmodule

//--- testbench/hyperframe_side_stream_scrambler_tb_top.sv
// self-checking bench for the side-stream scrambler
`timescale 1ns/1ps
module hyperframe_side_stream_scrambler_tb_top;
    import hssc_pkg::*;
    // ==========================================
    // setup
    localparam int TP = 8;
    localparam int NB = 40;
    logic        clk, resetn, stall, tx_in_valid, rx_in_valid;
    logic        tx_in_ready, tx_out_valid, tx_out_ready, rx_out_valid;
    logic        rx_locked, rx_lock_lost, scram_active;
    hssc_rate_t  line_rate;
    logic [7:0]  proto_version;
    logic [30:0] tx_seed;
    hssc_byte_t  tx_in, tx_out, rx_in, rx_out;
    int          n_fail, compares;
    int msk[16] = '{0, 1, 4*TP, 4*TP+1, 128*TP, 128*TP+1, 132*TP, 132*TP+1, 256*TP,
        256*TP+1, 260*TP, 260*TP+1, 384*TP, 384*TP+1, 388*TP, 388*TP+1};

    hssc_top #(.T(TP)) dut (.clk(clk), .resetn(resetn), .line_rate(line_rate),
        .proto_version(proto_version), .tx_seed(tx_seed), .tx_in(tx_in),
        .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_out(tx_out),
        .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .rx_in(rx_in),
        .rx_in_valid(rx_in_valid), .rx_out(rx_out), .rx_out_valid(rx_out_valid),
        .rx_locked(rx_locked), .rx_lock_lost(rx_lock_lost), .scram_active(scram_active));
    hssc_sink sink (.clk(clk), .stall(stall), .tx_out(tx_out),
        .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================
    // tasks
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask

    task stop_test;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // inputs held until ready seen high before the taking edge
    task send(input logic hf, input logic [7:0] d);
        logic ok;
        int   i;
        tx_in = '{hf_start: hf, data: d};
        tx_in_valid = 1'b1;
        ok = 1'b0;
        for (i = 0; i < 300 && !ok; i++)
        begin
            ok = tx_in_ready;
            @(negedge clk);
        end
        if (!ok)
        begin
            n_fail++;
            stop_test();
        end
    endtask

    task drain(input int n);
        int i;
        for (i = 0; i < 3000 && sink.got.size() < n; i++)
            @(negedge clk);
        check(9'(sink.got.size()), 9'(n));
    endtask

    // two hyperframes of NB bytes; the model rebuilds the sequence bit by bit
    task automatic run(input hssc_rate_t r, input logic [7:0] v, input logic [30:0] sd);
        bit         c[$];
        logic [7:0] exp_q[$];
        logic [7:0] d, m;
        int         i, k;
        line_rate = r;
        proto_version = v;
        tx_seed = sd;
        sink.got.delete();
        repeat (3) @(negedge clk);
        for (i = 0; i < 8*NB; i++)
            c.push_back(i < 31 ? sd[i] : c[i-31] ^ c[i-28]);
        for (k = 0; k < 2*NB; k++)
        begin
            d = 8'($urandom);
            for (i = 0; i < 8; i++)
                m[i] = c[8*(k%NB)+i];
            if (!(r >= HSSC_RATE_4915 && v == 8'h02) || ((k%NB) inside {msk}))
                m = 8'h00;
            exp_q.push_back(d ^ m);
            send(k % NB == 0, d);
        end
        tx_in_valid = 1'b0;
        drain(2*NB);
        for (k = 0; k < 2*NB && k < sink.got.size(); k++)
            check(sink.got[k], {k % NB == 0, exp_q[k]});
    endtask

    // ==========================================
    // receive traffic runs freely; t=8 has no control bytes 2.., so rx never locks
    logic rx_chk_en;
    always @(negedge clk)
    begin
        if (rx_chk_en)
        begin
            check({8'h00, rx_out_valid}, {8'h00, rx_in_valid});
            if (rx_in_valid)
                check(rx_out, rx_in);
            check({7'h00, rx_locked, rx_lock_lost}, 9'h000);
        end
        rx_chk_en <= resetn;
        rx_in <= hssc_byte_t'($urandom);
        rx_in_valid <= $urandom % 2;
    end

    // ==========================================
    // main sequence
    initial
    begin
        int r, v, k;
        void'($urandom(89529));
        resetn = 1'b0;
        stall = 1'b0;
        tx_in_valid = 1'b0;
        tx_in = '0;
        line_rate = HSSC_RATE_614;
        proto_version = 8'h01;
        tx_seed = 31'h00000000;
        n_fail = 0;
        compares = 0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        for (r = 0; r < 7; r++)
            for (v = 1; v < 3; v++)
            begin
                line_rate = hssc_rate_t'(r);
                proto_version = 8'(v);
                repeat (3) @(negedge clk);
                check({8'h00, scram_active}, {8'h00, r >= 4 && v == 2});
            end
        run(HSSC_RATE_9830, 8'h02, 31'(($urandom << 1) | 1));
        run(HSSC_RATE_4915, 8'h02, 31'h5A3C0F01);
        run(HSSC_RATE_6144, 8'h02, 31'h00000000);
        run(HSSC_RATE_9830, 8'h01, 31'h12345678);
        run(HSSC_RATE_3072, 8'h02, 31'h12345678);
        // fill the buffer against a stalled sink, then drain it
        sink.got.delete();
        stall = 1'b1;
        tx_in_valid = 1'b1;
        k = 0;
        for (r = 0; r < 20 && tx_in_ready === 1'b1; r++)
        begin
            tx_in = '{hf_start: k == 0, data: 8'(k)};
            k++;
            @(negedge clk);
        end
        tx_in_valid = 1'b0;
        check(9'(k >= HSSC_FIFO_DEPTH && k <= HSSC_FIFO_DEPTH + 2), 9'h001);
        stall = 1'b0;
        drain(k);
        for (r = 0; r < k && r < sink.got.size(); r++)
            check(sink.got[r], {r == 0, 8'(r)});
        stop_test();
    end
endmodule
